// ### pkg/sfrib_pkg.sv
// Package: offsets, field positions, reset values and carriers of the special-function bank.
package sfrib_pkg;

  // ----------------------------------------------------------------
  // Register indices (printed offsets) and byte addresses
  // ----------------------------------------------------------------
  localparam logic [3:0]  IDX_IRQ_EN_ONE   = 4'h0;
  localparam logic [3:0]  IDX_IRQ_EN_TWO   = 4'h1;
  localparam logic [3:0]  IDX_IRQ_FLAG_ONE = 4'h2;
  localparam logic [3:0]  IDX_IRQ_FLAG_TWO = 4'h3;
  localparam logic [3:0]  IDX_SPACE_TOP    = 4'hF;
  localparam logic [3:0]  IDX_WDOG_CTRL    = 4'h8;
  localparam logic [3:0]  IDX_EVT_STATUS   = 4'h9;
  localparam logic [3:0]  IDX_EVT_MASK     = 4'hA;
  localparam int          ADDR_LSB         = 2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_WDOG     = 0;
  localparam int BIT_OSC      = 1;
  localparam int BIT_PWRUP    = 2;
  localparam int BIT_PINRST   = 3;
  localparam int BIT_NMI      = 4;
  localparam int BIT_ACCV     = 5;

  // ----------------------------------------------------------------
  // Implemented-bit masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] EN_ONE_MASK    = 8'h33;
  localparam logic [7:0] EN_ONE_PUC_VAL = 8'h00;
  localparam logic [7:0] FLAG_MASK      = 8'h1F;
  localparam logic [7:0] FLAG_PUC_MASK  = 8'h12;
  localparam logic [7:0] FLAG_PUC_VAL   = 8'h02;
  localparam logic [7:0] FLAG_POR_VAL   = 8'h04;
  localparam logic [7:0] EVT_MASK_BITS  = 8'h3F;
  localparam logic [7:0] ZERO_BYTE      = 8'h00;

  // Watchdog control fields.
  localparam int          WD_MODE_LSB  = 0;
  localparam int          WD_SEL_LSB   = 2;
  localparam logic [1:0]  WD_SEL_RESET = 2'h0;
  localparam logic [15:0] WD_DIV_MAX   = 16'hFFFF;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SFRIB_WD_OFF      = 3'b001,
    SFRIB_WD_RESET    = 3'b010,
    SFRIB_WD_INTERVAL = 3'b100
  } sfrib_wd_mode_t;

  typedef struct packed {
    logic osc_fault;
    logic nmi_edge;
    logic pin_reset;
    logic access_viol;
  } sfrib_events_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } sfrib_apb_req_t;

endpackage

// ### rtl/sfrib_bank.sv
// Special-function register bank: enables, system flags, watchdog and APB slave.
`timescale 1ns/100ps
module sfrib_bank
  import sfrib_pkg::*;
(
  // Clock and resets
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        brownout_rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Asynchronous event pins
  input  wire sfrib_pkg::sfrib_events_t event_pins,
  // System outputs
  output logic             power_up_clear,
  output logic             irq,
  output logic             nmi_req,
  output logic [7:0]       irq_en_out
);
  import sfrib_pkg::*;

  // ----------------------------------------------------------------
  // Synchronised events
  // ----------------------------------------------------------------
  logic [3:0]    ev_sync;
  sfrib_events_t ev;
  logic [3:0]    ev_prev_ff;
  logic [3:0]    ev_rise;

  sfrib_sync #(.W(4)) u_sync (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .async_in (event_pins),
    .sync_out (ev_sync)
  );

  assign ev      = sfrib_events_t'(ev_sync);
  assign ev_rise = ev_sync & ~ev_prev_ff;

  // Brownout is an external level; synchronise it before use.
  logic bo_meta_ff;
  logic bo_sync_ff;
  logic por;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bo_meta_ff <= 1'b1;
      bo_sync_ff <= 1'b1;
      ev_prev_ff <= '0;
    end else begin
      bo_meta_ff <= brownout_rst;
      bo_sync_ff <= bo_meta_ff;
      ev_prev_ff <= ev_sync;
    end
  end

  // Power-on is sys_rst or the brownout level; both restore the POR bits.
  assign por = sys_rst || bo_sync_ff;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic       acc;
  logic       wr;
  logic [3:0] idx;
  logic       in_space;
  logic       wr_en1;
  logic       wr_flag;
  logic       wr_wdc;
  logic       wr_sts;
  logic       wr_msk;
  logic [7:0] wbyte;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
    return a == b;
  endfunction

  assign acc      = psel && penable;
  assign idx      = paddr[ADDR_LSB +: 4];
  assign in_space = (paddr[31:ADDR_LSB+4] == '0) && (idx <= IDX_SPACE_TOP);
  assign wr       = acc && pwrite && in_space && pstrb[0];
  assign wbyte    = pwdata[7:0];
  assign wr_en1   = wr && hit(idx, IDX_IRQ_EN_ONE);
  assign wr_flag  = wr && hit(idx, IDX_IRQ_FLAG_ONE);
  assign wr_wdc   = wr && hit(idx, IDX_WDOG_CTRL);
  assign wr_sts   = wr && hit(idx, IDX_EVT_STATUS);
  assign wr_msk   = wr && hit(idx, IDX_EVT_MASK);
  assign pready   = 1'b1;
  assign pslverr  = acc && !in_space;

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  logic [7:0]     wdc_ff;
  sfrib_wd_mode_t wd_mode;
  logic           wd_expired;
  logic           wd_reset_evt;
  logic           wd_tick_evt;
  logic           puc_ff;

  // Mode field 0 off, 1 reset, 2/3 interval timer.
  assign wd_mode = (wdc_ff[WD_MODE_LSB +: 2] == 2'h0) ? SFRIB_WD_OFF
                 : (wdc_ff[WD_MODE_LSB +: 2] == 2'h1) ? SFRIB_WD_RESET
                 : SFRIB_WD_INTERVAL;

  sfrib_watchdog u_wd (
    .ref_clk      (ref_clk),
    .sys_rst      (puc_ff),
    .mode         (wd_mode),
    .interval_sel (wdc_ff[WD_SEL_LSB +: 2]),
    .restart      (wr_wdc),
    .expired      (wd_expired)
  );

  assign wd_reset_evt = wd_expired && (wd_mode == SFRIB_WD_RESET);
  assign wd_tick_evt  = wd_expired && (wd_mode == SFRIB_WD_INTERVAL);

  // Power-up clear: one cycle after a power-on or a watchdog reset.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      puc_ff <= 1'b1;
    end else begin
      puc_ff <= por || wd_reset_evt;
    end
  end
  assign power_up_clear = puc_ff;

  // Watchdog control is cleared by power-up clear so a reset loop stops.
  always_ff @(posedge ref_clk) begin
    if (puc_ff) begin
      wdc_ff <= ZERO_BYTE;
    end else if (wr_wdc) begin
      wdc_ff <= wbyte;
    end
  end

  // ----------------------------------------------------------------
  // Enable register one
  // ----------------------------------------------------------------
  logic [7:0] en1_ff;

  // Only implemented positions store; others stay constant zero.
  always_ff @(posedge ref_clk) begin
    if (puc_ff) begin
      en1_ff <= EN_ONE_PUC_VAL;
    end else if (wr_en1) begin
      en1_ff <= wbyte & EN_ONE_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Flag register one
  // ----------------------------------------------------------------
  logic [7:0] flag_set;
  logic [7:0] flag_puc_ff;
  logic [7:0] flag_por_ff;
  logic [7:0] nxt_flag_puc;
  logic [7:0] nxt_flag_por;
  logic [7:0] flags;

  assign flag_set = {3'h0, ev_rise[2], ev.pin_reset, 1'b0, ev.osc_fault,
                     wd_reset_evt || wd_tick_evt};

  // A hardware set wins over a software write in the same cycle.
  assign nxt_flag_puc = ((wr_flag ? wbyte : flag_puc_ff) | flag_set) & FLAG_PUC_MASK;
  assign nxt_flag_por = ((wr_flag ? wbyte : flag_por_ff) | flag_set)
                        & FLAG_MASK & ~FLAG_PUC_MASK;

  // Bits 4 and 1 restore on power-up clear.
  always_ff @(posedge ref_clk) begin
    if (puc_ff) begin
      flag_puc_ff <= FLAG_PUC_VAL | (flag_set & FLAG_PUC_MASK);
    end else begin
      flag_puc_ff <= nxt_flag_puc;
    end
  end

  // Bits 3, 2, 0 restore only on power-on; they survive a watchdog reset.
  always_ff @(posedge ref_clk) begin
    if (por) begin
      flag_por_ff <= FLAG_POR_VAL;
    end else begin
      flag_por_ff <= nxt_flag_por;
    end
  end

  assign flags = flag_puc_ff | flag_por_ff;

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  logic [7:0] sts_ff;
  logic [7:0] msk_ff;
  logic [7:0] sts_set;
  logic       wd_irq_ok;

  // Interval enable only counts in interval mode.
  assign wd_irq_ok = en1_ff[BIT_WDOG] && (wd_mode == SFRIB_WD_INTERVAL);
  assign sts_set   = {2'h0, ev_rise[0], ev_rise[2], 2'h0, ev_rise[3], wd_tick_evt};

  always_ff @(posedge ref_clk) begin
    if (puc_ff) begin
      sts_ff <= ZERO_BYTE;
      msk_ff <= ZERO_BYTE;
    end else begin
      sts_ff <= ((wr_sts ? sts_ff & ~wbyte : sts_ff) | sts_set) & EVT_MASK_BITS;
      if (wr_msk) begin
        msk_ff <= wbyte & EVT_MASK_BITS;
      end
    end
  end

  assign irq = |(sts_ff & msk_ff) || (wd_irq_ok && flags[BIT_WDOG]);
  assign nmi_req = (en1_ff[BIT_NMI] && flags[BIT_NMI])
                || (en1_ff[BIT_OSC] && flags[BIT_OSC])
                || (en1_ff[BIT_ACCV] && sts_ff[BIT_ACCV]);
  assign irq_en_out = {en1_ff[7:1], wd_irq_ok};

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] rbyte;

  assign rbyte = hit(idx, IDX_IRQ_EN_ONE)   ? en1_ff
               : hit(idx, IDX_IRQ_FLAG_ONE) ? flags
               : hit(idx, IDX_WDOG_CTRL)    ? wdc_ff
               : hit(idx, IDX_EVT_STATUS)   ? sts_ff
               : hit(idx, IDX_EVT_MASK)     ? msk_ff
               : ZERO_BYTE;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h0, in_space ? rbyte : ZERO_BYTE};
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_wd_fire;
    wd_reset_evt;
  endsequence

  a_wd_reset_puc: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_wd_fire |=> puc_ff ##1 flag_por_ff[BIT_WDOG])
    else $error("watchdog expiry did not reset");
  a_en_two_empty: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (psel && !penable && !pwrite && hit(idx, IDX_IRQ_EN_TWO)) |=> prdata == 32'h0)
    else $error("enable two not empty");
  a_unimpl_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ((en1_ff & ~EN_ONE_MASK) == 8'h00) && ((flags & ~FLAG_MASK) == 8'h00))
    else $error("unimplemented bit holds state");
  a_puc_en_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
    puc_ff |=> en1_ff == EN_ONE_PUC_VAL)
    else $error("enable not cleared by power-up clear");
  a_por_keep: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (puc_ff && !$past(por) && !por) |=> flag_por_ff[BIT_PWRUP] == $past(flag_por_ff[BIT_PWRUP]))
    else $error("power-on bit changed on power-up clear");
  a_osc_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (ev.osc_fault && !por) |=> flags[BIT_OSC])
    else $error("oscillator flag not set");
  a_wd_en_mask: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (wd_mode == SFRIB_WD_RESET) |-> !irq_en_out[BIT_WDOG])
    else $error("interval enable active in reset mode");
  a_brownout_por: assert property (@(posedge ref_clk) disable iff (sys_rst)
    bo_sync_ff |=> flag_por_ff == FLAG_POR_VAL)
    else $error("brownout did not restore power-on bits");
  a_space_err: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (acc && (paddr[31:ADDR_LSB+4] != '0)) |-> pslverr)
    else $error("access outside space not flagged");

  // The pin flag follows the level, so a held pin keeps setting it.
  sequence s_pin_level;
    ev.pin_reset && !por;
  endsequence

  a_pin_flag_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_pin_level |=> flags[BIT_PINRST])
    else $error("pin reset flag not set");
  a_osc_status_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ($rose(ev.osc_fault) && !puc_ff) |=> sts_ff[BIT_OSC])
    else $error("oscillator status bit not set");
  a_puc_osc_restore: assert property (@(posedge ref_clk) disable iff (sys_rst)
    puc_ff |=> flag_puc_ff[BIT_OSC])
    else $error("oscillator flag not set by power-up clear");

endmodule

// ### rtl/sfrib_sync.sv
// Two-flop synchroniser for a group of asynchronous pin levels.
`timescale 1ns/100ps
module sfrib_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1_ff;
  logic [W-1:0] stage2_ff;

  // The first stage feeds only the second, so metastability is not spread.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else begin
      stage1_ff <= async_in;
      stage2_ff <= stage1_ff;
    end
  end

  assign sync_out = stage2_ff;

endmodule

// ### rtl/sfrib_watchdog.sv
// Watchdog counter that either resets the system or ticks as an interval timer.
`timescale 1ns/100ps
module sfrib_watchdog
  import sfrib_pkg::*;
(
  // Clock and reset
  input  wire logic           ref_clk,
  input  wire logic           sys_rst,
  // Configuration
  input  wire sfrib_pkg::sfrib_wd_mode_t mode,
  input  wire logic [1:0]     interval_sel,
  input  wire logic           restart,
  // Results
  output logic                expired
);
  import sfrib_pkg::*;

  logic [15:0] prescale_ff;
  logic [15:0] nxt_prescale;
  logic [1:0]  count_ff;
  logic [1:0]  nxt_count;
  logic        tick;
  logic        running;

  // Interval is (interval_sel+1) prescaler wraps; the prescaler is the slow enable.
  assign running      = (mode != SFRIB_WD_OFF);
  assign tick         = running && (prescale_ff == WD_DIV_MAX);
  assign nxt_prescale = (!running || restart) ? '0 : prescale_ff + 16'h0001;
  assign expired      = tick && (count_ff == interval_sel);
  assign nxt_count    = (!running || restart || expired) ? '0
                      : (tick ? count_ff + 2'h1 : count_ff);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prescale_ff <= '0;
      count_ff    <= '0;
    end else begin
      prescale_ff <= nxt_prescale;
      count_ff    <= nxt_count;
    end
  end

endmodule

// ### verif/sfrib_bank_tb.sv
// Self-checking testbench for the special-function register bank.
`timescale 1ns/100ps
module sfrib_bank_tb;
  import sfrib_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic          ref_clk;
  logic          sys_rst;
  logic          brownout_rst;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [31:0]   paddr;
  logic [31:0]   pwdata;
  logic [3:0]    pstrb;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  sfrib_events_t event_pins;
  logic          power_up_clear;
  logic          irq;
  logic          nmi_req;
  logic [7:0]    irq_en_out;
  logic [31:0]   rdv;
  logic          errv;
  int            error_cnt = 0;
  int            tests_run = 0;
  int            pin_idx [3] = '{3, 2, 0};
  int            st_bit [3]  = '{1, 4, 5};

  sfrib_bank DUT (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .brownout_rst(brownout_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .event_pins(event_pins), .power_up_clear(power_up_clear),
    .irq(irq), .nmi_req(nmi_req), .irq_en_out(irq_en_out)
  );

  // The clock toggles every 5 ns, half of its 10 ns period.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] ba(input logic [3:0] idx);
    return 32'(idx) << ADDR_LSB;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is seen at an edge.
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    pstrb   <= s;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hF);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, 4'hF);
    chk(rdv, exp);
  endtask

  // Pins pass a two-flop synchroniser, so each level is held several cycles.
  task automatic pulse(input int k);
    @(posedge ref_clk);
    event_pins[k] <= 1'b1;
    repeat (6) @(posedge ref_clk);
    event_pins[k] <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask

  task automatic end_test(input string name);
    $display("test %s done, errors so far %0d", name, error_cnt);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // A full watchdog countdown dominates the run, so the limit sits above it.
  initial begin
    repeat (100000) @(posedge ref_clk);
    error_cnt++;
    $display("[FAIL] t=%0t timeout", $time);
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    brownout_rst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    event_pins = '0;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rdc(ba(IDX_IRQ_EN_ONE), 32'h00);
    rdc(ba(IDX_IRQ_FLAG_ONE), 32'h06);
    end_test("reset");
    // Only the listed bits hold state; the empty bytes read zero.
    wr(ba(IDX_IRQ_EN_ONE), 32'hFF);
    rdc(ba(IDX_IRQ_EN_ONE), 32'h33);
    wr(ba(IDX_IRQ_EN_TWO), 32'hFF);
    rdc(ba(IDX_IRQ_EN_TWO), 32'h00);
    wr(ba(IDX_IRQ_FLAG_TWO), 32'hFF);
    rdc(ba(IDX_IRQ_FLAG_TWO), 32'h00);
    wr(ba(IDX_IRQ_FLAG_ONE), 32'hFF);
    rdc(ba(IDX_IRQ_FLAG_ONE), 32'h1F);
    wr(ba(IDX_IRQ_FLAG_ONE), 32'h00);
    rdc(ba(IDX_IRQ_FLAG_ONE), 32'h00);
    xfer(1'b0, 32'h40, 32'h0, 4'hF);
    chk(32'(errv), 32'h1);
    rdc(32'h3C, 32'h00);
    chk(32'(errv), 32'h0);
    wr(ba(IDX_IRQ_EN_ONE), 32'h00);
    // A write without the low byte lane must leave the register alone.
    xfer(1'b1, ba(IDX_IRQ_EN_ONE), 32'h33, 4'hE);
    rdc(ba(IDX_IRQ_EN_ONE), 32'h00);
    end_test("map");
    // Each event sets its sticky bit; the mask gates the interrupt line.
    for (int i = 0; i < 3; i++) begin
      wr(ba(IDX_EVT_MASK), 32'h0);
      pulse(pin_idx[i]);
      rdc(ba(IDX_EVT_STATUS), 32'h1 << st_bit[i]);
      chk(32'(irq), 32'h0);
      wr(ba(IDX_EVT_MASK), 32'h1 << st_bit[i]);
      chk(32'(irq), 32'h1);
      wr(ba(IDX_EVT_STATUS), 32'h1 << st_bit[i]);
      rdc(ba(IDX_EVT_STATUS), 32'h0);
      chk(32'(irq), 32'h0);
    end
    pulse(1);
    rdc(ba(IDX_IRQ_FLAG_ONE), 32'h1A);
    wr(ba(IDX_IRQ_EN_ONE), 32'h10);
    chk(32'(nmi_req), 32'h1);
    end_test("events");
    // The interval enable only reaches the system in interval mode.
    wr(ba(IDX_IRQ_EN_ONE), 32'h01);
    wr(ba(IDX_WDOG_CTRL), 32'h01);
    chk(32'(irq_en_out), 32'h00);
    wr(ba(IDX_WDOG_CTRL), 32'h02);
    chk(32'(irq_en_out), 32'h01);
    wr(ba(IDX_WDOG_CTRL), 32'h00);
    end_test("interval gating");
    // Watchdog expiry restores plain bits to their power-up-clear values but keeps power-on-only bits.
    wr(ba(IDX_IRQ_EN_ONE), 32'h33);
    wr(ba(IDX_IRQ_FLAG_ONE), 32'h18);
    wr(ba(IDX_WDOG_CTRL), 32'h01);
    errv = 1'b0;
    for (int n = 0; n < 70000 && !errv; n++) begin
      @(posedge ref_clk);
      errv = (power_up_clear === 1'b1);
    end
    chk(32'(errv), 32'h1);
    for (int n = 0; n < 20 && power_up_clear !== 1'b0; n++) @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
    rdc(ba(IDX_IRQ_EN_ONE), 32'h00);
    rdc(ba(IDX_IRQ_FLAG_ONE), 32'h0B);
    rdc(ba(IDX_WDOG_CTRL), 32'h00);
    end_test("watchdog reset");
    // A brownout acts as power-on and restores every flag.
    @(posedge ref_clk);
    brownout_rst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    brownout_rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rdc(ba(IDX_IRQ_FLAG_ONE), 32'h06);
    rdc(ba(IDX_IRQ_EN_ONE), 32'h00);
    end_test("brownout");
    tally_and_finish();
  end
endmodule
